// File: design/pavr_cfg.svh
/*
 * Register numbers, field positions, reset values and decode codes
 * of the auto-negotiation and vendor register bank.
 * Assumes inclusion by bare name from the package and modules.
 */
`ifndef PAVR_CFG_SVH
`define PAVR_CFG_SVH

`define PAVR_ADDR_W 5
`define PAVR_DATA_W 16

`define PAVR_ADDR_PARTNER 5'h05
`define PAVR_ADDR_EXPANSION 5'h06
`define PAVR_ADDR_VENDOR 5'h10

`define PAVR_RST_PARTNER 16'h0000
`define PAVR_RST_EXPANSION 16'h0000
`define PAVR_RST_VENDOR 16'h0140

`define PAVR_VMC_FIXED_MASK 16'hFFC0
`define PAVR_BIT_AUTO_POL_DIS 5
`define PAVR_BIT_RX_POL 4
`define PAVR_BIT_BYPASS 1
`define PAVR_BIT_RXCLK_GATE 0

`define PAVR_SEL_LSB 0
`define PAVR_SEL_MSB 4
`define PAVR_SEL_802_3 5'h01
`define PAVR_SEL_802_9 5'h02
`define PAVR_SEL_802_5 5'h03
`define PAVR_SEL_1394 5'h04

`endif

// File: design/pavr_pkg.sv
/*
 * Types shared by the register bank and its helper modules.
 * Assumes pavr_cfg.svh is on the include path.
 */
`default_nettype none
`include "pavr_cfg.svh"

package pavr_pkg;

  typedef struct packed {
    logic req;
    logic wr;
    logic [`PAVR_ADDR_W-1:0] addr;
    logic [`PAVR_DATA_W-1:0] wdata;
  } pavr_mgmt_req_t;

  typedef struct packed {
    logic valid;
    logic [`PAVR_DATA_W-1:0] word;
  } pavr_page_t;

  typedef enum logic [2:0] {
    PAVR_SEL_RESERVED = 3'h0,
    PAVR_SEL_ETH = 3'h1,
    PAVR_SEL_ISLAN = 3'h2,
    PAVR_SEL_TOKEN = 3'h3,
    PAVR_SEL_FIREWIRE = 3'h4
  } pavr_selector_t;

endpackage

`default_nettype wire

// File: design/pavr_polarity.sv
/*
 * Receive polarity control: automatic correction or software force.
 * Assumes detection strobes come from the 10Base-T receive path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pavr_cfg.svh"

module pavr_polarity
  import pavr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic auto_disable_i,
  input wire logic force_invert_i,
  input wire logic speed_10_i,
  input wire logic detect_valid_i,
  input wire logic detect_reversed_i,
  output logic auto_invert_o,
  output logic invert_o
);

  logic auto_invert;
  logic invert;
  logic next_auto_invert;
  logic next_invert;

  always_comb
  begin
    next_auto_invert = auto_invert;
    if (auto_disable_i)
      next_auto_invert = 1'b0;
    else if (detect_valid_i && speed_10_i)
      next_auto_invert = detect_reversed_i;
    if (auto_disable_i)
      next_invert = force_invert_i;
    else
      next_invert = next_auto_invert;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      auto_invert <= 1'b0;
      invert <= 1'b0;
    end
    else
    begin
      auto_invert <= next_auto_invert;
      invert <= next_invert;
    end
  end

  assign auto_invert_o = auto_invert;
  assign invert_o = invert;

endmodule

`default_nettype wire

// File: design/pavr_rx_clock_gate.sv
/*
 * Receive clock power saving: enable for the receive clock.
 * Assumes activity and mode inputs are synchronous to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module pavr_rx_clock_gate
  import pavr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic gate_enable_i,
  input wire logic speed_100_i,
  input wire logic loopback_i,
  input wire logic rx_activity_i,
  output logic rx_clk_enable_o
);

  logic rx_clk_enable;
  logic next_rx_clk_enable;
  logic saving;

  always_comb
  begin
    saving = gate_enable_i && speed_100_i && !loopback_i;
    next_rx_clk_enable = !(saving && !rx_activity_i);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      rx_clk_enable <= 1'b1;
    else
      rx_clk_enable <= next_rx_clk_enable;
  end

  assign rx_clk_enable_o = rx_clk_enable;

endmodule

`default_nettype wire

// File: design/pavr_regs.sv
/*
 * Auto-negotiation partner, expansion and vendor control registers.
 * Assumes a management engine delivering one-cycle register requests
 * and auto-negotiation logic delivering captured page words.
 */
// Overview of operation
// - Capture partner abilities, read-only, reset zero
// - Decode partner selector field codes
// - Read-only expansion register reporting negotiation abilities
// - Vendor control resets to 0x0140, writable fields
// - Auto-polarity disable bit turns correction off
// - Auto-invert reversed 10Base-T receive polarity
// - Polarity bit read-only status while auto
// - Polarity bit forces inversion when auto disabled
// - Bypass bit routes 100Base-TX around coding
// - Clock control gates receive clock when idle
// - Clock saving only in 100Base-TX
// - Loopback overrides receive clock saving
`timescale 1ns/1ps
`default_nettype none
`include "pavr_cfg.svh"

module pavr_regs
  import pavr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire pavr_mgmt_req_t mgmt_i,
  output logic [`PAVR_DATA_W-1:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  output logic mgmt_hit_o,
  input wire pavr_page_t partner_page_i,
  input wire pavr_page_t expansion_i,
  input wire logic speed_10_i,
  input wire logic speed_100_i,
  input wire logic loopback_select_i,
  input wire logic pol_detect_valid_i,
  input wire logic pol_detect_reversed_i,
  input wire logic rx_activity_i,
  output pavr_selector_t partner_selector_o,
  output logic receive_polarity_invert_o,
  output logic coding_sublayer_bypass_o,
  output logic rx_clk_enable_o
);

  logic [`PAVR_DATA_W-1:0] partner_base_page_ability;
  logic [`PAVR_DATA_W-1:0] autoneg_expansion;
  logic auto_polarity_disable;
  logic receive_polarity_force;
  logic coding_sublayer_bypass;
  logic receive_clock_gating;
  logic [`PAVR_DATA_W-1:0] rdata;
  logic rvalid;
  logic hit;
  pavr_selector_t selector;

  logic [`PAVR_DATA_W-1:0] next_partner_base_page_ability;
  logic [`PAVR_DATA_W-1:0] next_autoneg_expansion;
  logic next_auto_polarity_disable;
  logic next_receive_polarity_force;
  logic next_coding_sublayer_bypass;
  logic next_receive_clock_gating;
  logic [`PAVR_DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_hit;
  pavr_selector_t next_selector;

  logic auto_invert;
  logic invert;
  logic vendor_wr;
  logic [4:0] sel_code;
  logic [`PAVR_DATA_W-1:0] vendor_view;
  logic coding_sublayer_bypass_out;
  logic next_coding_sublayer_bypass_out;
  logic rd_req;
  logic wr_req;
  logic sel_partner;
  logic sel_expansion;
  logic sel_vendor;

  // Vendor reset pattern, indexable per field
  localparam logic [`PAVR_DATA_W-1:0] vendor_reset = `PAVR_RST_VENDOR;

  // Polarity correction and force
  pavr_polarity u_polarity (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .auto_disable_i(auto_polarity_disable),
    .force_invert_i(receive_polarity_force),
    .speed_10_i(speed_10_i),
    .detect_valid_i(pol_detect_valid_i),
    .detect_reversed_i(pol_detect_reversed_i),
    .auto_invert_o(auto_invert),
    .invert_o(invert)
  );

  // Receive clock power saving
  pavr_rx_clock_gate u_rx_clock_gate (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .gate_enable_i(receive_clock_gating),
    .speed_100_i(speed_100_i),
    .loopback_i(loopback_select_i),
    .rx_activity_i(rx_activity_i),
    .rx_clk_enable_o(rx_clk_enable_o)
  );

  // Register number decode
  always_comb
  begin
    rd_req = mgmt_i.req && !mgmt_i.wr;
    wr_req = mgmt_i.req && mgmt_i.wr;
    sel_partner = (mgmt_i.addr == `PAVR_ADDR_PARTNER);
    sel_expansion = (mgmt_i.addr == `PAVR_ADDR_EXPANSION);
    sel_vendor = (mgmt_i.addr == `PAVR_ADDR_VENDOR);
  end

  // Vendor register as software sees it
  always_comb
  begin
    vendor_view = `PAVR_RST_VENDOR & `PAVR_VMC_FIXED_MASK;
    vendor_view[`PAVR_BIT_AUTO_POL_DIS] = auto_polarity_disable;
    if (auto_polarity_disable)
      vendor_view[`PAVR_BIT_RX_POL] = receive_polarity_force;
    else
      vendor_view[`PAVR_BIT_RX_POL] = auto_invert;
    vendor_view[`PAVR_BIT_BYPASS] = coding_sublayer_bypass;
    vendor_view[`PAVR_BIT_RXCLK_GATE] = receive_clock_gating;
  end

  // Partner page capture
  always_comb
  begin
    next_partner_base_page_ability = partner_base_page_ability;
    if (partner_page_i.valid)
      next_partner_base_page_ability = partner_page_i.word;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      partner_base_page_ability <= `PAVR_RST_PARTNER;
    end
    else
    begin
      partner_base_page_ability <= next_partner_base_page_ability;
    end
  end

  // Expansion word capture
  always_comb
  begin
    next_autoneg_expansion = autoneg_expansion;
    if (expansion_i.valid)
      next_autoneg_expansion = expansion_i.word;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      autoneg_expansion <= `PAVR_RST_EXPANSION;
    end
    else
    begin
      autoneg_expansion <= next_autoneg_expansion;
    end
  end

  // Selector decode of the captured word
  always_comb
  begin
    sel_code = next_partner_base_page_ability[`PAVR_SEL_MSB:`PAVR_SEL_LSB];
    unique case (sel_code)
      `PAVR_SEL_802_3: next_selector = PAVR_SEL_ETH;
      `PAVR_SEL_802_9: next_selector = PAVR_SEL_ISLAN;
      `PAVR_SEL_802_5: next_selector = PAVR_SEL_TOKEN;
      `PAVR_SEL_1394: next_selector = PAVR_SEL_FIREWIRE;
      default: next_selector = PAVR_SEL_RESERVED;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      selector <= PAVR_SEL_RESERVED;
    end
    else
    begin
      selector <= next_selector;
    end
  end

  // Vendor control writes
  always_comb
  begin
    vendor_wr = wr_req && sel_vendor;
    next_auto_polarity_disable = auto_polarity_disable;
    next_receive_polarity_force = receive_polarity_force;
    next_coding_sublayer_bypass = coding_sublayer_bypass;
    next_receive_clock_gating = receive_clock_gating;
    if (vendor_wr)
    begin
      next_auto_polarity_disable =
        mgmt_i.wdata[`PAVR_BIT_AUTO_POL_DIS];
      if (mgmt_i.wdata[`PAVR_BIT_AUTO_POL_DIS])
        next_receive_polarity_force =
          mgmt_i.wdata[`PAVR_BIT_RX_POL];
      next_coding_sublayer_bypass =
        mgmt_i.wdata[`PAVR_BIT_BYPASS];
      next_receive_clock_gating =
        mgmt_i.wdata[`PAVR_BIT_RXCLK_GATE];
    end
  end

  // Vendor control state
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      auto_polarity_disable <= vendor_reset[`PAVR_BIT_AUTO_POL_DIS];
      receive_polarity_force <= vendor_reset[`PAVR_BIT_RX_POL];
      coding_sublayer_bypass <= vendor_reset[`PAVR_BIT_BYPASS];
      receive_clock_gating <= vendor_reset[`PAVR_BIT_RXCLK_GATE];
    end
    else
    begin
      auto_polarity_disable <= next_auto_polarity_disable;
      receive_polarity_force <= next_receive_polarity_force;
      coding_sublayer_bypass <= next_coding_sublayer_bypass;
      receive_clock_gating <= next_receive_clock_gating;
    end
  end

  // Read path, one cycle after the request
  always_comb
  begin
    next_rvalid = rd_req;
    next_hit = 1'b0;
    next_rdata = rdata;
    if (rd_req)
    begin
      next_rdata = {`PAVR_DATA_W{1'b0}};
      if (sel_partner)
      begin
        next_hit = 1'b1;
        next_rdata = partner_base_page_ability;
      end
      if (sel_expansion)
      begin
        next_hit = 1'b1;
        next_rdata = autoneg_expansion;
      end
      if (sel_vendor)
      begin
        next_hit = 1'b1;
        next_rdata = vendor_view;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rdata <= {`PAVR_DATA_W{1'b0}};
      rvalid <= 1'b0;
      hit <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      hit <= next_hit;
    end
  end

  // Bypass acts on the 100Base-TX path only
  always_comb
  begin
    next_coding_sublayer_bypass_out = coding_sublayer_bypass
      && speed_100_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      coding_sublayer_bypass_out <= 1'b0;
    end
    else
    begin
      coding_sublayer_bypass_out <= next_coding_sublayer_bypass_out;
    end
  end

  assign mgmt_rdata_o = rdata;
  assign mgmt_rvalid_o = rvalid;
  assign mgmt_hit_o = hit;
  assign partner_selector_o = selector;
  assign receive_polarity_invert_o = invert;
  assign coding_sublayer_bypass_o = coding_sublayer_bypass_out;

endmodule

`default_nettype wire

// File: verif/pavr_regs_asserts.sv
/* Port checker for the register bank.
   Assumes binding onto every pavr_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module pavr_regs_chk
  import pavr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire pavr_mgmt_req_t mgmt_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic mgmt_rvalid_o,
  input wire logic mgmt_hit_o,
  input wire pavr_page_t partner_page_i,
  input wire logic speed_100_i,
  input wire logic loopback_select_i,
  input wire pavr_selector_t partner_selector_o,
  input wire logic receive_polarity_invert_o,
  input wire logic coding_sublayer_bypass_o,
  input wire logic rx_clk_enable_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  sequence rd_s;
    mgmt_i.req && !mgmt_i.wr;
  endsequence
  sequence wr10_s;
    mgmt_i.req && mgmt_i.wr && mgmt_i.addr == 5'h10 && mgmt_i.wdata[5];
  endsequence
  sequence byp_wr_s;
    mgmt_i.req && mgmt_i.wr && mgmt_i.addr == 5'h10 && mgmt_i.wdata[1];
  endsequence
  rd_valid_a: assert property (rd_s |=> mgmt_rvalid_o)
    else $error("read without valid");
  vendor_fix_a: assert property (rd_s ##0 mgmt_i.addr == 5'h10 |=>
    mgmt_hit_o && mgmt_rdata_o[15:6] == 10'h005 && !mgmt_rdata_o[3:2])
    else $error("vendor fixed bits wrong");
  unmapped_rd_a: assert property (rd_s ##0
    !(mgmt_i.addr inside {5'h05, 5'h06, 5'h10}) |=> !mgmt_hit_o)
    else $error("unmapped read hit");
  sel_token_a: assert property (partner_page_i.valid &&
    partner_page_i.word[4:0] == 5'h03 |=> partner_selector_o == PAVR_SEL_TOKEN)
    else $error("selector token wrong");
  sel_rsvd_a: assert property (partner_page_i.valid &&
    partner_page_i.word[4:0] > 5'h04 |=>
    partner_selector_o == PAVR_SEL_RESERVED)
    else $error("selector reserved wrong");
  pol_set_a: assert property (wr10_s ##0 mgmt_i.wdata[4] |->
    ##[1:3] receive_polarity_invert_o)
    else $error("forced inversion missing");
  pol_clr_a: assert property (wr10_s ##0 !mgmt_i.wdata[4] |->
    ##[1:3] !receive_polarity_invert_o)
    else $error("forced inversion stuck");
  loop_ovr_a: assert property (loopback_select_i |=> rx_clk_enable_o)
    else $error("clock gated in loopback");
  bypass_spd_a: assert property (!speed_100_i |=>
    !coding_sublayer_bypass_o)
    else $error("bypass outside 100M");
  bypass_on_a: assert property (byp_wr_s ##0 speed_100_i ##1
    (speed_100_i && !mgmt_i.req) [*2] |=> coding_sublayer_bypass_o)
    else $error("bypass not applied");
endmodule
bind pavr_regs pavr_regs_chk i_pavr_regs_chk (.clock_i(clock_i),
  .reset_i(reset_i), .mgmt_i(mgmt_i), .mgmt_rdata_o(mgmt_rdata_o),
  .mgmt_rvalid_o(mgmt_rvalid_o), .mgmt_hit_o(mgmt_hit_o),
  .partner_page_i(partner_page_i), .speed_100_i(speed_100_i),
  .loopback_select_i(loopback_select_i),
  .partner_selector_o(partner_selector_o),
  .receive_polarity_invert_o(receive_polarity_invert_o),
  .coding_sublayer_bypass_o(coding_sublayer_bypass_o),
  .rx_clk_enable_o(rx_clk_enable_o));
`default_nettype wire

// File: verif/pavr_link_partner.sv
/* Link partner model: page words and polarity detection.
   Assumes tasks are called by the bench at a falling edge. */
`timescale 1ns/1ps
`default_nettype none
module pavr_link_partner
  import pavr_pkg::*;
(
  input wire logic clock_i,
  output pavr_page_t page_o,
  output pavr_page_t exp_o,
  output logic det_o,
  output logic rev_o
);
  initial
  begin
    page_o = '0;
    exp_o = '0;
    det_o = 1'b0;
    rev_o = 1'b0;
  end
  // One-cycle page pulse, word scrambled afterwards
  task automatic send(input logic e, input logic [15:0] w);
    @(negedge clock_i);
    if (e)
      exp_o = '{1'b1, w};
    else
      page_o = '{1'b1, w};
    @(negedge clock_i);
    page_o = '{1'b0, ~w};
    exp_o = '{1'b0, ~w};
  endtask
  task automatic detect(input logic r);
    @(negedge clock_i);
    det_o = 1'b1;
    rev_o = r;
    @(negedge clock_i);
    det_o = 1'b0;
    rev_o = !r;
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
/* Self-checking bench for the register bank.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pavr_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  pavr_mgmt_req_t m = '0;
  logic s10 = 1'b0, s100 = 1'b0, lb = 1'b0, act = 1'b0;
  pavr_page_t pg, ex;
  logic det, rev, rv, hit, inv, byp, rxe;
  logic [15:0] rd, d;
  pavr_selector_t sel;
  logic [16:0] q[$];
  logic [16:0] e;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #50 clock_i = ~clock_i;
  pavr_regs i_pavr_regs (.clock_i(clock_i), .reset_i(reset_i), .mgmt_i(m),
    .mgmt_rdata_o(rd), .mgmt_rvalid_o(rv), .mgmt_hit_o(hit),
    .partner_page_i(pg), .expansion_i(ex), .speed_10_i(s10),
    .speed_100_i(s100), .loopback_select_i(lb), .pol_detect_valid_i(det),
    .pol_detect_reversed_i(rev), .rx_activity_i(act),
    .partner_selector_o(sel), .receive_polarity_invert_o(inv),
    .coding_sublayer_bypass_o(byp), .rx_clk_enable_o(rxe));
  pavr_link_partner i_pavr_link_partner (.clock_i(clock_i), .page_o(pg),
    .exp_o(ex), .det_o(det), .rev_o(rev));
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] x);
    n_compared++;
    if (s !== x)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
    m = '{1'b1, w, a, v};
    if (!w)
      q.push_back({a inside {5'h05, 5'h06, 5'h10}, v});
    @(negedge clock_i);
  endtask
  task automatic idle(input int n);
    m.req = 1'b0;
    repeat (n) @(negedge clock_i);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clock_i)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      fail_count++;
      finish_test();
    end
    else if (rv === 1'b1)
    begin
      e = q.pop_front();
      chk("rdata", rd, e[15:0]);
      chk("hit", 16'(hit), 16'(e[16]));
    end
  end
  initial
  begin
    void'($urandom(32'h0D8E));
    repeat (16) @(negedge clock_i);
    reset_i = 1'b0;
    acc(0, 5'h05, 16'h0000);
    acc(0, 5'h06, 16'h0000);
    acc(0, 5'h10, 16'h0140);
    acc(0, 5'h07, 16'h0000);
    acc(1, 5'h05, 16'hFFFF);
    acc(0, 5'h05, 16'h0000);
    idle(3);
    $display("reset values done");
    repeat (4)
    begin
      d = $urandom;
      d[5] = 1'b1;
      d[3:2] = 2'h0;
      d[1] = 1'b0;
      acc(1, 5'h10, d);
      idle(1);
      acc(0, 5'h10, 16'h0140 | (d & 16'h0033));
      idle(3);
      chk("inv", 16'(inv), 16'(d[4]));
    end
    $display("vendor writes done");
    acc(1, 5'h10, 16'h0010);
    idle(1);
    s10 = 1'b1;
    i_pavr_link_partner.detect(1'b1);
    idle(3);
    chk("inv", 16'(inv), 16'h0001);
    acc(0, 5'h10, 16'h0150);
    idle(1);
    s10 = 1'b0;
    i_pavr_link_partner.detect(1'b0);
    idle(3);
    chk("inv", 16'(inv), 16'h0001);
    acc(1, 5'h10, 16'h0020);
    idle(1);
    s10 = 1'b1;
    i_pavr_link_partner.detect(1'b1);
    idle(3);
    chk("inv", 16'(inv), 16'h0000);
    $display("polarity done");
    for (int c = 0; c < 8; c++)
    begin
      d = $urandom;
      d[4:0] = (c == 7) ? 5'h1F : 5'(c);
      i_pavr_link_partner.send(1'b0, d);
      idle(2);
      chk("sel", 16'(sel), (c < 5) ? 16'(c) : 16'h0000);
      acc(0, 5'h05, d);
      idle(2);
    end
    d = $urandom;
    i_pavr_link_partner.send(1'b1, d);
    idle(2);
    acc(0, 5'h06, d);
    idle(3);
    $display("capture done");
    acc(1, 5'h10, 16'h0021);
    idle(1);
    s100 = 1'b1;
    idle(3);
    chk("rxe", 16'(rxe), 16'h0000);
    act = 1'b1;
    idle(2);
    chk("rxe", 16'(rxe), 16'h0001);
    act = 1'b0;
    lb = 1'b1;
    idle(2);
    chk("rxe", 16'(rxe), 16'h0001);
    lb = 1'b0;
    s100 = 1'b0;
    idle(2);
    chk("rxe", 16'(rxe), 16'h0001);
    s100 = 1'b1;
    acc(1, 5'h10, 16'h0022);
    idle(2);
    chk("byp", 16'(byp), 16'h0001);
    acc(1, 5'h10, 16'h0020);
    idle(2);
    chk("byp", 16'(byp), 16'h0000);
    $display("clock gating done");
    finish_test();
  end
endmodule
`default_nettype wire
